/* File: core/usb_irq_pkg.sv */
// Purpose: constants and types for the usb interrupt flag block
// Assumes: core_clk at 40 MHz, byte-wide flag register in the low bits
// Notes:   offsets are word byte addresses on the plain register port
//
// Summary of operation
// - host: received stall handshake sets stall
// - peripheral: sent stall handshake sets stall
// - host: attach detection sets attach flag
// - attach only when host, bus quiet 2.5 us, not se0
// - k state held 2.5 us sets resume
// - idle bus 3 ms sets idle
// - token finished sets token done flag
// - clearing token done advances status fifo
// - sof received (peripheral) or threshold (host) sets frame start
// - only enabled errors set error summary
// - peripheral: valid bus reset sets bit zero
// - host: detach sets bit zero
// - sticky flags, write one clears
// - upper 24 bits read zero
package usb_irq_pkg;

  localparam logic [7:0] FLAGS_OFFSET   = 8'h00;
  localparam logic [7:0] ENABLE_OFFSET  = 8'h04;
  localparam logic [7:0] ERR_EN_OFFSET  = 8'h08;
  localparam logic [7:0] CONTROL_OFFSET = 8'h0C;
  localparam logic [7:0] LINE_OFFSET    = 8'h10;

  localparam int STALL_BIT  = 7;
  localparam int ATTACH_BIT = 6;
  localparam int RESUME_BIT = 5;
  localparam int IDLE_BIT   = 4;
  localparam int TOKEN_BIT  = 3;
  localparam int FRAME_BIT  = 2;
  localparam int ERROR_BIT  = 1;
  localparam int RESET_BIT  = 0;

  localparam int HOST_EN_BIT = 0;

  localparam int LINE_SUSP_BIT = 2;

  localparam logic [7:0] FLAGS_RESET  = 8'h00;
  localparam logic [7:0] ENABLE_RESET = 8'h00;
  localparam logic [7:0] ERR_EN_RESET = 8'h00;
  localparam logic [7:0] CTRL_RESET   = 8'h00;
  localparam logic [1:0] LINE_RESET   = 2'h1;

  localparam int CLK_HZ       = 40_000_000;
  localparam int RESUME_NS    = 2500;
  localparam int ATTACH_NS    = 2500;
  localparam int IDLE_US      = 3000;
  localparam int RESUME_TICKS = (RESUME_NS * (CLK_HZ / 1_000_000)
                                 + 999) / 1000;
  localparam int ATTACH_TICKS = (ATTACH_NS * (CLK_HZ / 1_000_000)
                                 + 999) / 1000;
  localparam int IDLE_TICKS   = IDLE_US * (CLK_HZ / 1_000_000);
  localparam int CNT_W        = 17;

  typedef enum logic [1:0] {
    line_se0,
    line_j,
    line_k,
    line_se1
  } line_state_type;

  typedef struct packed {
    logic       stall_rx;
    logic       stall_tx;
    logic       attach;
    logic       token_done;
    logic       sof_rx;
    logic       sof_threshold;
    logic       bus_reset;
    logic       detach;
    logic [7:0] error_events;
  } usb_event_type;

  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic        write;
    logic        read;
  } reg_request_type;

endpackage

/* File: core/usb_interrupt_flags.sv */
// Purpose: sticky usb interrupt flags, enables and interrupt request
// Assumes: events are one-cycle pulses on core_clk; line state is a pin
// Notes:   flags clear on write-one; enabled flags drive one level irq
//
// The register offsets and the strobed register port were decided locally.
`timescale 1ns/10ps
module usb_interrupt_flags
  import usb_irq_pkg::*;
#(
  parameter int IDLE_COUNT = IDLE_TICKS
) (
  input  wire logic            core_clk,
  input  wire logic            rstn,
  input  wire reg_request_type bus_req,
  output logic [31:0]          rdata,
  input  wire usb_event_type   events,
  input  wire logic [1:0]      line_pins,
  input  wire logic            suspended,
  output logic                 status_advance,
  output logic                 irq
);

  ////////////////////////////////////////////////////////////////////////
  // pin synchroniser
  logic [1:0] line_meta;
  logic [1:0] line_sync;
  logic [1:0] line_prev;
  logic [1:0] next_line_meta;
  logic [1:0] next_line_sync;
  logic [1:0] next_line_prev;
  logic       line_moved;

  // only the second stage onward is read: the first may be metastable
  always_comb begin
    next_line_meta = line_pins;
    next_line_sync = line_meta;
    next_line_prev = line_sync;
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      line_meta <= LINE_RESET;
      line_sync <= LINE_RESET;
      line_prev <= LINE_RESET;
    end else begin
      line_meta <= next_line_meta;
      line_sync <= next_line_sync;
      line_prev <= next_line_prev;
    end
  end

  // any change of the settled line counts as bus activity
  assign line_moved = (line_sync != line_prev);

  line_state_type line_now;
  assign line_now = line_state_type'(line_sync);

  function automatic logic hit(input reg_request_type r,
                               input logic [7:0] off);
    hit = r.write && (r.addr == off);
  endfunction

  // host and peripheral share flag bits with different sources
  function automatic logic by_mode(input logic host,
                                   input logic host_src,
                                   input logic dev_src);
    by_mode = host ? host_src : dev_src;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // control registers
  logic [7:0] flags;
  logic [7:0] enables;
  logic [7:0] err_en;
  logic [7:0] control;
  logic [7:0] next_flags;
  logic [7:0] next_enables;
  logic [7:0] next_err_en;
  logic [7:0] next_control;
  logic       host_mode;

  assign host_mode = control[HOST_EN_BIT];

  always_comb begin
    next_enables = enables;
    next_err_en  = err_en;
    next_control = control;
    if (hit(bus_req, ENABLE_OFFSET)) begin
      next_enables = bus_req.wdata[7:0];
    end
    if (hit(bus_req, ERR_EN_OFFSET)) begin
      next_err_en = bus_req.wdata[7:0];
    end
    if (hit(bus_req, CONTROL_OFFSET)) begin
      next_control = bus_req.wdata[7:0];
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      enables <= ENABLE_RESET;
      err_en  <= ERR_EN_RESET;
      control <= CTRL_RESET;
    end else begin
      enables <= next_enables;
      err_en  <= next_err_en;
      control <= next_control;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // line timers
  logic [CNT_W-1:0] k_count;
  logic [CNT_W-1:0] next_k_count;
  logic             resume_hit;

  // k state timer, saturates so one long k sets once
  always_comb begin
    next_k_count = k_count;
    resume_hit   = 1'b0;
    if (line_now != line_k) begin
      next_k_count = '0;
    end else if (k_count < CNT_W'(RESUME_TICKS)) begin
      next_k_count = k_count + CNT_W'(1);
      resume_hit   = (k_count == CNT_W'(RESUME_TICKS - 1));
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      k_count <= '0;
    end else begin
      k_count <= next_k_count;
    end
  end

  logic [CNT_W-1:0] idle_count;
  logic [CNT_W-1:0] next_idle_count;
  logic             idle_hit;

  // idle timer, fires once per idle period
  always_comb begin
    next_idle_count = idle_count;
    idle_hit        = 1'b0;
    if (line_now != line_j) begin
      next_idle_count = '0;
    end else if (idle_count < CNT_W'(IDLE_COUNT)) begin
      next_idle_count = idle_count + CNT_W'(1);
      idle_hit        = (idle_count == CNT_W'(IDLE_COUNT - 1));
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      idle_count <= '0;
    end else begin
      idle_count <= next_idle_count;
    end
  end

  logic [CNT_W-1:0] quiet_count;
  logic [CNT_W-1:0] next_quiet_count;
  logic             bus_quiet;

  // quiet bus means no line change and no token traffic
  always_comb begin
    next_quiet_count = quiet_count;
    if (line_moved || events.token_done) begin
      next_quiet_count = '0;
    end else if (quiet_count < CNT_W'(ATTACH_TICKS)) begin
      next_quiet_count = quiet_count + CNT_W'(1);
    end
  end

  assign bus_quiet = (quiet_count >= CNT_W'(ATTACH_TICKS));

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      quiet_count <= '0;
    end else begin
      quiet_count <= next_quiet_count;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // flag set and clear
  logic [7:0] set_vec;
  logic [7:0] clear_vec;

  always_comb begin
    set_vec = '0;
    set_vec[STALL_BIT] = by_mode(host_mode, events.stall_rx,
                                 events.stall_tx);
    set_vec[ATTACH_BIT] = events.attach && host_mode && bus_quiet
                          && (line_now != line_se0);
    set_vec[RESUME_BIT] = resume_hit;
    set_vec[IDLE_BIT]   = idle_hit;
    set_vec[TOKEN_BIT]  = events.token_done;
    set_vec[FRAME_BIT]  = by_mode(host_mode, events.sof_threshold,
                                  events.sof_rx);
    set_vec[ERROR_BIT]  = |(events.error_events & err_en);
    set_vec[RESET_BIT]  = by_mode(host_mode, events.detach,
                                  events.bus_reset);
    clear_vec = hit(bus_req, FLAGS_OFFSET) ? bus_req.wdata[7:0] : 8'h00;
    next_flags = (flags & ~clear_vec) | set_vec;
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      flags <= FLAGS_RESET;
    end else begin
      flags <= next_flags;
    end
  end

  assign status_advance = flags[TOKEN_BIT] && clear_vec[TOKEN_BIT];

  assign irq = |(flags & enables);

  ////////////////////////////////////////////////////////////////////////
  // read port, data one cycle after strobe
  logic [31:0] next_rdata;

  always_comb begin
    next_rdata = 32'h0000_0000;
    if (bus_req.read) begin
      case (bus_req.addr)
        FLAGS_OFFSET:   next_rdata = {24'h00_0000, flags};
        ENABLE_OFFSET:  next_rdata = {24'h00_0000, enables};
        ERR_EN_OFFSET:  next_rdata = {24'h00_0000, err_en};
        CONTROL_OFFSET: next_rdata = {24'h00_0000, control};
        LINE_OFFSET: begin
          next_rdata[1:0]           = line_sync;
          next_rdata[LINE_SUSP_BIT] = suspended;
        end
        default:        next_rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rdata <= 32'h0000_0000;
    end else begin
      rdata <= next_rdata;
    end
  end

endmodule

/* File: verif/usb_interrupt_flags_checker.sv */
// Purpose: port checks for usb_interrupt_flags
// Assumes: one clock, rstn async active low
// Notes:   attached by bind after the module
`timescale 1ns/10ps
module usb_interrupt_flags_checker
  import usb_irq_pkg::*;
(
  input wire logic            core_clk,
  input wire logic            rstn,
  input wire reg_request_type bus_req,
  input wire logic [31:0]     rdata,
  input wire usb_event_type   events,
  input wire logic            status_advance,
  input wire logic            irq
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);
  wire rd_f   = bus_req.read && bus_req.addr == FLAGS_OFFSET;
  wire wr_f   = bus_req.write && bus_req.addr == FLAGS_OFFSET;
  wire clr_t  = wr_f && bus_req.wdata[TOKEN_BIT];
  wire zero_w = wr_f && bus_req.wdata[7:0] == 8'h00;
  wire off_e  = bus_req.write && bus_req.addr == ENABLE_OFFSET
                && bus_req.wdata[7:0] == 8'h00;
  //////////////////////////////////////////////////////////////
  a_upper_zero: assert property (rdata[31:8] == 24'h0)
    else $error("upper read bits set");
  a_advance_cause: assert property (status_advance |-> clr_t)
    else $error("advance without token clear");
  a_token_sets: assert property (events.token_done
    ##1 !bus_req.write ##1 rd_f |=> rdata[TOKEN_BIT])
    else $error("token flag missing");
  a_flags_sticky: assert property (rd_f ##1 rd_f |=>
    (rdata[7:0] & $past(rdata[7:0])) == $past(rdata[7:0]))
    else $error("flag lost between reads");
  a_clear_one: assert property (clr_t
    && !events.token_done ##1 rd_f |=> !rdata[TOKEN_BIT])
    else $error("token flag not cleared");
  a_zero_keeps: assert property (rd_f ##1 zero_w ##1 rd_f |=>
    (rdata[7:0] & $past(rdata[7:0], 2)) == $past(rdata[7:0], 2))
    else $error("zero write changed flags");
  a_irq_fall: assert property ($fell(irq) |-> $past(bus_req.write))
    else $error("irq dropped without write");
  a_irq_masked: assert property (off_e |=> !irq)
    else $error("irq with enables off");
endmodule
bind usb_interrupt_flags usb_interrupt_flags_checker chk_i (.core_clk,
  .rstn, .bus_req, .rdata, .events, .status_advance, .irq);

/* File: verif/usb_far_end.sv */
// Purpose: remote usb party: line states and bus events
// Assumes: events last one core_clk cycle
// Notes:   line starts in se0 so no idle timer runs early
`timescale 1ns/10ps
module usb_far_end
  import usb_irq_pkg::*;
(
  input  wire logic    core_clk,
  output usb_event_type events,
  output logic [1:0]   line_pins
);
  initial begin
    events = '0;
    line_pins = line_se0;
  end
  task pulse(input usb_event_type e);
    @(posedge core_clk) events <= e;
    @(posedge core_clk) events <= '0;
  endtask
  task hold(input line_state_type s, input int n);
    @(posedge core_clk) line_pins <= s;
    repeat (n) @(posedge core_clk);
  endtask
endmodule

/* File: verif/test_usb_interrupt_flags.sv */
// Purpose: self-checking bench for usb_interrupt_flags
// Assumes: IDLE_COUNT shortened to 20 cycles
// Notes:   bus inputs change by nba at rising edges
`timescale 1ns/10ps
module test_usb_interrupt_flags
  import usb_irq_pkg::*;
;
  logic            core_clk, rstn, suspended, status_advance, irq;
  reg_request_type bus_req;
  logic [31:0]     rdata;
  usb_event_type   events, h, p, e;
  logic [1:0]      line_pins;
  int              checked, miscompares;
  logic [7:0]      offs [5] = '{FLAGS_OFFSET, ENABLE_OFFSET,
                                ERR_EN_OFFSET, CONTROL_OFFSET, 8'h14};
  usb_interrupt_flags #(.IDLE_COUNT(20)) DUT (.core_clk, .rstn, .bus_req,
    .rdata, .events, .line_pins, .suspended, .status_advance, .irq);
  usb_far_end far (.core_clk, .events, .line_pins);
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  ////////////////////////////////////////////////////////////////
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task acc(input logic [7:0] a, input logic [31:0] d, input logic w);
    @(posedge core_clk) bus_req <= '{a, d, w, !w};
    @(posedge core_clk) bus_req <= '0;
    #1;
  endtask
  task rd(input logic [7:0] a, input logic [31:0] exp);
    acc(a, 32'h0, 1'b0);
    chk(rdata, exp);
  endtask
  // read, write zero, then three reads, the first two back-to-back
  task probe(input logic [31:0] exp);
    @(posedge core_clk) bus_req <= '{FLAGS_OFFSET, 32'h0, 1'b0, 1'b1};
    @(posedge core_clk) bus_req <= '{FLAGS_OFFSET, 32'h0, 1'b1, 1'b0};
    @(posedge core_clk) bus_req <= '{FLAGS_OFFSET, 32'h0, 1'b0, 1'b1};
    repeat (2) rd(FLAGS_OFFSET, exp);
  endtask
  task test_done;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  task t_modes;
    h = '0;
    p = '0;
    e = '0;
    {h.stall_rx, h.sof_threshold, h.detach} = 3'h7;
    {p.stall_tx, p.sof_rx, p.bus_reset, p.token_done} = 4'hF;
    e.error_events = 8'h02;
    far.pulse(h);
    rd(FLAGS_OFFSET, 32'h0);
    far.pulse(p);
    rd(FLAGS_OFFSET, 32'h8D);
    probe(32'h8D);
    far.pulse(e);
    rd(FLAGS_OFFSET, 32'h8D);
    acc(ERR_EN_OFFSET, 32'h02, 1'b1);
    far.pulse(e);
    rd(FLAGS_OFFSET, 32'h8F);
    @(posedge core_clk) bus_req <= '{FLAGS_OFFSET, 32'hFF, 1'b1, 1'b0};
    #1 chk(32'(status_advance), 32'h1);
    rd(FLAGS_OFFSET, 32'h0);
    acc(CONTROL_OFFSET, 32'h1, 1'b1);
    far.pulse(p);
    rd(FLAGS_OFFSET, 32'h08);
    far.pulse(h);
    rd(FLAGS_OFFSET, 32'h8D);
    e = '0;
    e.token_done = 1'b1;
    fork
      far.pulse(e);
      acc(FLAGS_OFFSET, 32'h08, 1'b1);
    join
    rd(FLAGS_OFFSET, 32'h8D);
    acc(FLAGS_OFFSET, 32'hFF, 1'b1);
    $display("mode events done");
  endtask
  task t_line;
    e = '0;
    e.attach = 1'b1;
    far.hold(line_j, 30);
    far.pulse(e);
    rd(FLAGS_OFFSET, 32'h10);
    far.hold(line_j, 100);
    far.pulse(e);
    rd(FLAGS_OFFSET, 32'h50);
    acc(CONTROL_OFFSET, 32'h0, 1'b1);
    acc(FLAGS_OFFSET, 32'hFF, 1'b1);
    @(posedge core_clk) suspended <= 1'b1;
    acc(ENABLE_OFFSET, 32'h20, 1'b1);
    far.hold(line_k, 90);
    rd(FLAGS_OFFSET, 32'h0);
    chk(32'(irq), 32'h0);
    far.hold(line_k, 20);
    rd(FLAGS_OFFSET, 32'h20);
    rd(LINE_OFFSET, 32'h6);
    chk(32'(irq), 32'h1);
    acc(ENABLE_OFFSET, 32'h0, 1'b1);
    chk(32'(irq), 32'h0);
    acc(ENABLE_OFFSET, 32'h20, 1'b1);
    acc(FLAGS_OFFSET, 32'h20, 1'b1);
    chk(32'(irq), 32'h0);
    $display("line events done");
  endtask
  initial begin
    bus_req = '0;
    suspended = 1'b0;
    rstn = 1'b0;
    repeat (5) @(posedge core_clk);
    rstn <= 1'b1;
    foreach (offs[i]) rd(offs[i], 32'h0);
    $display("reset values done");
    t_modes;
    t_line;
    test_done;
  end
  initial begin
    #100000;
    miscompares++;
    test_done;
  end
endmodule
